/* watch_buzzer_clock_pkg.sv */
// constants for the watch, watchdog and buzzer clock selection block
`default_nettype none
package watch_buzzer_clock_pkg;
  // register offsets (16-bit byte addresses)
  localparam logic [15:0] CLK_SEL_OFFSET      = 16'hff42;  // watch_buzzer_clock_select
  localparam logic [15:0] OSC_MODE_OFFSET     = 16'hfff0;  // oscillation_mode_register
  localparam logic [15:0] WATCH_MODE_OFFSET   = 16'hff4a;  // watch_mode_control
  localparam logic [15:0] WATCH_STATUS_OFFSET = 16'hff4b;  // sticky watch flags

  // reset values
  localparam logic [7:0] CLK_SEL_RESET      = 8'h00;
  localparam logic [7:0] OSC_MODE_RESET     = 8'h00;
  localparam logic [7:0] WATCH_MODE_RESET   = 8'h00;
  localparam logic [7:0] WATCH_STATUS_RESET = 8'h00;

  // clock select field positions
  localparam int WDOG_SEL_LSB     = 0;  // bits 2..0
  localparam int WDOG_SEL_W       = 3;
  localparam int FIXED_ZERO_BIT   = 3;  // always reads zero
  localparam int WATCH_SRC_BIT    = 4;
  localparam int BUZ_FREQ_LSB     = 5;  // bits 6..5
  localparam int BUZ_FREQ_W       = 2;
  localparam int BUZ_EN_BIT       = 7;
  localparam logic [7:0] CLK_SEL_WMASK = 8'hf7;

  // oscillation mode field
  localparam int FULL_RATE_BIT    = 0;

  // watch mode fields
  localparam int FAST_FWD_BIT     = 0;
  localparam int PRESC_EN_BIT     = 1;
  localparam int COUNT_EN_BIT     = 2;
  localparam int SET_TIME_BIT     = 3;
  localparam int INTV_SEL_LSB     = 4;  // bits 6..4
  localparam int INTV_SEL_W       = 3;
  localparam logic [7:0] WATCH_MODE_WMASK = 8'h7f;

  // watch status fields (write one to clear)
  localparam int OVF_FLAG_BIT     = 0;
  localparam int INTV_FLAG_BIT    = 1;

  // divider figures, as powers of two
  localparam int MAIN_DIV_W       = 12;  // covers fxx/2^11
  localparam int WDOG_BASE_EXP    = 3;   // code 000 -> fxx/2^3
  localparam int WDOG_TOP_EXP     = 11;  // code 111 -> fxx/2^11
  localparam int WATCH_MAIN_EXP   = 7;   // fxx/2^7
  localparam int BUZ_BASE_EXP     = 9;   // code 00 -> fxx/2^9
  localparam int WATCH_CNT_W      = 14;
  localparam int WATCH_PRESC_W    = 9;
  localparam int WATCH_NORMAL_EXP = 14;  // flag every 2^14 watch clocks
  localparam int WATCH_SHORT_EXP  = 13;
  localparam int WATCH_FAST_EXP   = 5;
  localparam int INTV_BASE_EXP    = 4;   // code 000 -> 2^4 watch clocks
  localparam int INTV_CODES       = 6;   // six reference times
  localparam real SUB_CLK_KHZ     = 32.768;  // subsystem clock rate
endpackage

`default_nettype wire

/* watch_buzzer_clock.sv */
// watch, watchdog and buzzer clock selection with watch timer
//
// Behaviour
// - watch timer overflows every half second
// - interval function with six reference times
// - watch and interval functions run together
// - 8-bit RW select register, reset zero
// - watchdog clock fxx/2^3..2^9, code 7: 2^11
// - watch clock fxx/2^7 or subsystem clock
// - buzzer enable, fxx/2^9..2^11, code 11 prohibited
// - fxx is fx or fx/2 by mode bit
// - overflow flag every 2^14 watch clocks
`timescale 1ns/1ps
`default_nettype none

module watch_buzzer_clock
  import watch_buzzer_clock_pkg::*;
(
  input  wire logic        clk_sys_in,       // oscillator clock fx, 40 MHz
  input  wire logic        resetn_in,        // async active-low reset
  input  wire logic        sub_clk_in,       // subsystem clock pin, 32.768 kHz
  input  wire logic [15:0] addr_in,          // register address
  input  wire logic [7:0]  wdata_in,         // register write data
  input  wire logic        wr_in,            // write strobe
  input  wire logic        rd_in,            // read strobe
  output logic      [7:0]  rdata_out,        // read data, cycle after rd_in
  output logic             wdog_tick_out,    // watchdog count clock pulse
  output logic             watch_tick_out,   // watch count clock pulse
  output logic             watch_ovf_out,    // watch overflow pulse
  output logic             intv_out,         // interval pulse
  output logic             buzzer_out        // buzzer square wave
);
  import watch_buzzer_clock_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  // every flop of the block except the reset synchroniser lives in this one record, so the
  // reset and the register process each touch it in one place;
  // adding a field here is all a new flop needs
  typedef struct packed {
    logic [7:0]             clk_sel;       // watch_buzzer_clock_select
    logic [7:0]             osc_mode;      // oscillation_mode_register
    logic [7:0]             watch_mode;    // watch_mode_control
    logic [7:0]             status;        // sticky flags
    logic [7:0]             rdata;         // read answer
    logic                   half_phase;    // fx/2 toggle
    logic [MAIN_DIV_W-1:0]  main_div;      // fxx divider chain
    logic                   sub_s1;        // synchroniser stage 1
    logic                   sub_s2;        // synchroniser stage 2
    logic                   sub_s3;        // edge history
    logic [WATCH_CNT_W-1:0] watch_cnt;     // prescaler and 5-bit counter
    logic                   wdog_tick;
    logic                   watch_tick;
    logic                   watch_ovf;
    logic                   intv;
    logic                   buzzer;
  } state_t;

  state_t     s_q;      // registered state
  state_t     s_d;      // next state
  // reset synchroniser and the copy that the state register uses
  logic [1:0] rst_sync_q;  // reset release synchroniser
  logic       rst_n;       // synchronised reset

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // carry out of the low n bits when every one of them is set
  // the loop runs to a fixed bound so the value of n never
  // shapes the hardware; bits at and above n are simply skipped,
  // and n of zero gives a carry on every call
  function automatic logic low_ones(input logic [WATCH_CNT_W-1:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < WATCH_CNT_W; i++) begin
      if (i < n) begin
        r = r & v[i];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release

  // assert at once, release after two clock edges
  // the release edge of the pin is not tied to the clock, so it
  // is retimed here to keep every state flop clear of recovery
  // trouble; the assert side still acts without any clock
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  // one process computes the whole next state from s_q, the bus and the subsystem clock pin;
  // every field starts from its held value so nothing can latch
  always_comb begin
    logic                   fxx_tick;     // one main system clock cycle
    logic [MAIN_DIV_W-1:0]  div_next;     // divider after this tick
    logic [WATCH_CNT_W-1:0] div_ext;      // divider widened for carry test
    logic [2:0]             wdog_sel;
    logic [1:0]             buz_sel;
    int                     wdog_exp;
    int                     ovf_exp;
    int                     intv_exp;
    logic                   sub_edge;
    logic                   wtick;
    logic                   presc_en;
    logic                   count_en;
    logic                   ovf_ev;
    logic                   intv_ev;
    logic [7:0]             clr;
    // defaults: held state, quiet locals
    s_d      = s_q;
    fxx_tick = 1'b0;
    div_next = '0;
    div_ext  = '0;
    wdog_sel = '0;
    buz_sel  = '0;
    wdog_exp = 0;
    ovf_exp  = 0;
    intv_exp = 0;
    sub_edge = 1'b0;
    wtick    = 1'b0;
    presc_en = 1'b0;
    count_en = 1'b0;
    ovf_ev   = 1'b0;
    intv_ev  = 1'b0;
    clr      = '0;

    // main system clock: every fx cycle or every second one
    // the divider is never cleared, so all taps stay in phase
    // with each other whatever the select register holds
    s_d.half_phase = ~s_q.half_phase;
    fxx_tick = s_q.osc_mode[FULL_RATE_BIT] | s_q.half_phase;
    div_next = s_q.main_div + MAIN_DIV_W'(fxx_tick);
    s_d.main_div = div_next;
    div_ext = WATCH_CNT_W'(s_q.main_div);

    // watchdog count clock select
    // a tap fires once when its low bits are all ones; after a pulse
    // those bits are zero, so a code change can never shorten a gap
    // below eight cycles
    wdog_sel = s_q.clk_sel[WDOG_SEL_LSB +: WDOG_SEL_W];
    if (wdog_sel == 3'h7) begin
      wdog_exp = WDOG_TOP_EXP;
    end else begin
      wdog_exp = WDOG_BASE_EXP + int'(wdog_sel);
    end
    s_d.wdog_tick = fxx_tick & low_ones(div_ext, wdog_exp);

    // subsystem clock rising edge, read only after two stages
    // the third stage only keeps history for the edge test, so an
    // edge reaches the watch logic two to three cycles after the pin
    s_d.sub_s1 = sub_clk_in;
    s_d.sub_s2 = s_q.sub_s1;
    s_d.sub_s3 = s_q.sub_s2;
    sub_edge   = s_q.sub_s2 & ~s_q.sub_s3;

    // watch clock source
    // either way the watch logic sees a one-cycle tick, never a clock
    if (s_q.clk_sel[WATCH_SRC_BIT]) begin
      wtick = sub_edge;
    end else begin
      wtick = fxx_tick & low_ones(div_ext, WATCH_MAIN_EXP);
    end
    s_d.watch_tick = wtick;

    // watch prescaler and 5-bit counter; a stopped part is held clear
    // the upper counter advances only on a prescaler carry, so both
    // parts together form one 14-bit chain for the overflow taps
    presc_en = s_q.watch_mode[PRESC_EN_BIT];
    count_en = s_q.watch_mode[COUNT_EN_BIT];
    if (!presc_en) begin
      s_d.watch_cnt[WATCH_PRESC_W-1:0] = '0;
    end else if (wtick) begin
      s_d.watch_cnt[WATCH_PRESC_W-1:0] = s_q.watch_cnt[WATCH_PRESC_W-1:0] + WATCH_PRESC_W'(1);
    end
    if (!count_en) begin
      s_d.watch_cnt[WATCH_CNT_W-1:WATCH_PRESC_W] = '0;
    end else if (wtick && presc_en && low_ones(s_q.watch_cnt, WATCH_PRESC_W)) begin
      s_d.watch_cnt[WATCH_CNT_W-1:WATCH_PRESC_W] =
        s_q.watch_cnt[WATCH_CNT_W-1:WATCH_PRESC_W] + (WATCH_CNT_W - WATCH_PRESC_W)'(1);
    end

    // half-second overflow from the same chain as the interval
    // with a 32.768 kHz watch clock, 2^14 ticks make half a second;
    // short taps inside the prescaler do not need the upper counter,
    // which is why fast-forward still works with the counter stopped
    if (s_q.watch_mode[FAST_FWD_BIT]) begin
      ovf_exp = WATCH_FAST_EXP;
    end else if (s_q.watch_mode[SET_TIME_BIT]) begin
      ovf_exp = WATCH_SHORT_EXP;
    end else begin
      ovf_exp = WATCH_NORMAL_EXP;
    end
    ovf_ev = wtick && presc_en && (count_en || ovf_exp <= WATCH_PRESC_W)
             && low_ones(s_q.watch_cnt, ovf_exp);

    // interval taps; prohibited codes fall back to the longest one
    // the interval taps read the prescaler only, so they keep running
    // beside the overflow and never disturb it
    intv_exp = INTV_BASE_EXP + int'(s_q.watch_mode[INTV_SEL_LSB +: INTV_SEL_W]);
    if (intv_exp >= INTV_BASE_EXP + INTV_CODES) begin
      intv_exp = INTV_BASE_EXP + INTV_CODES - 1;
    end
    intv_ev = wtick && presc_en && low_ones(s_q.watch_cnt, intv_exp);
    s_d.watch_ovf = ovf_ev;
    s_d.intv      = intv_ev;

    // buzzer: a divider bit is a 50% square wave at fxx/2^n
    // bit n-1 of the divider toggles every 2^(n-1) fxx ticks;
    // the prohibited code and a disabled buzzer park the pin low,
    // and a code change only moves the tap, never restarts the wave
    buz_sel = s_q.clk_sel[BUZ_FREQ_LSB +: BUZ_FREQ_W];
    if (!s_q.clk_sel[BUZ_EN_BIT] || buz_sel == 2'h3) begin
      s_d.buzzer = 1'b0;
    end else begin
      s_d.buzzer = s_q.main_div[BUZ_BASE_EXP - 1 + int'(buz_sel)];
    end

    // register writes; rule of software stopping timers is not checked
    // a write lands at the strobe edge and shows in the next read;
    // bit 3 of the select register is masked so it stays zero
    if (wr_in) begin
      unique case (addr_in)
        CLK_SEL_OFFSET: begin
          s_d.clk_sel = wdata_in & CLK_SEL_WMASK;
        end
        OSC_MODE_OFFSET: begin
          s_d.osc_mode = {7'h00, wdata_in[FULL_RATE_BIT]};
        end
        WATCH_MODE_OFFSET: begin
          s_d.watch_mode = wdata_in & WATCH_MODE_WMASK;
        end
        WATCH_STATUS_OFFSET: begin
          clr = wdata_in;
        end
        default: begin
        end
      endcase
    end

    // sticky flags: a new event beats a clear in the same cycle
    // so software that clears a flag can never lose an event
    s_d.status[OVF_FLAG_BIT]  = ovf_ev  | (s_q.status[OVF_FLAG_BIT]  & ~clr[OVF_FLAG_BIT]);
    s_d.status[INTV_FLAG_BIT] = intv_ev | (s_q.status[INTV_FLAG_BIT] & ~clr[INTV_FLAG_BIT]);

    // read answer stands for exactly one cycle
    // unmapped addresses and idle cycles answer zero
    s_d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        CLK_SEL_OFFSET:      s_d.rdata = s_q.clk_sel & CLK_SEL_WMASK;
        OSC_MODE_OFFSET:     s_d.rdata = s_q.osc_mode;
        WATCH_MODE_OFFSET:   s_d.rdata = s_q.watch_mode;
        WATCH_STATUS_OFFSET: s_d.rdata = s_q.status;
        default:             s_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // the reset branch loads only the package's reset constants;
  // every other field, divider included, starts from zero

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q            <= '0;
      s_q.clk_sel    <= CLK_SEL_RESET;
      s_q.osc_mode   <= OSC_MODE_RESET;
      s_q.watch_mode <= WATCH_MODE_RESET;
      s_q.status     <= WATCH_STATUS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, straight from flip-flops
  // no logic sits between the state flops and the pins, so
  // every output is glitch free and changes just after an edge

  assign rdata_out      = s_q.rdata;
  assign wdog_tick_out  = s_q.wdog_tick;
  assign watch_tick_out = s_q.watch_tick;
  assign watch_ovf_out  = s_q.watch_ovf;
  assign intv_out       = s_q.intv;
  assign buzzer_out     = s_q.buzzer;

endmodule

`default_nettype wire

/* watch_buzzer_clock_props.sv */
// checker for the watch, watchdog and buzzer clock select block
`timescale 1ns/1ps
`default_nettype none

module watch_buzzer_clock_props
  import watch_buzzer_clock_pkg::*;
(
  input wire logic        clk_sys_in,     // system clock
  input wire logic        resetn_in,      // async reset, active low
  input wire logic        sub_clk_in,     // subsystem clock pin
  input wire logic [15:0] addr_in,        // register address
  input wire logic [7:0]  wdata_in,       // write data
  input wire logic        wr_in,          // write strobe
  input wire logic        rd_in,          // read strobe
  input wire logic [7:0]  rdata_out,      // read data
  input wire logic        wdog_tick_out,  // watchdog tick
  input wire logic        watch_tick_out, // watch tick
  input wire logic        watch_ovf_out,  // watch overflow
  input wire logic        intv_out,       // interval pulse
  input wire logic        buzzer_out      // buzzer wave
);
  logic [7:0]  sel_q;    // shadow of the select register
  logic [11:0] quiet_q;  // cycles since last select write
  logic [11:0] hi_q;     // length of current buzzer high run

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////
  // shadow state tracked from bus writes and the buzzer output
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_q   <= 8'h00;
      quiet_q <= 12'h000;
      hi_q    <= 12'h000;
    end else begin
      hi_q <= buzzer_out ? hi_q + 12'h001 : 12'h000;
      if (wr_in && addr_in == CLK_SEL_OFFSET) begin
        sel_q   <= wdata_in & CLK_SEL_WMASK;
        quiet_q <= 12'h000;
      end else if (quiet_q != 12'hfff) begin
        quiet_q <= quiet_q + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // steps of reads and buzzer disable
  sequence s_read_sel;
    rd_in && addr_in == CLK_SEL_OFFSET;
  endsequence
  sequence s_buz_idle;
    (!sel_q[7] || sel_q[6:5] == 2'b11) [*3];
  endsequence

  a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside read");
  a_read_sel_value: assert property (s_read_sel |=> rdata_out == $past(sel_q))
    else $error("select readback wrong");
  a_wdog_tick_gap: assert property (wdog_tick_out |=> (!wdog_tick_out) [*7])
    else $error("watchdog ticks too close");
  a_buzzer_off_idle: assert property (s_buz_idle |-> !buzzer_out)
    else $error("buzzer active while disabled");
  a_buzzer_half_len: assert property ($fell(buzzer_out) && quiet_q > 12'd2100 |-> hi_q >= 12'd256)
    else $error("buzzer half period short");
  a_watch_tick_gap: assert property (watch_tick_out && quiet_q > 12'd8 |=> (!watch_tick_out) [*3])
    else $error("watch ticks too close");
  a_ovf_pulse_gap: assert property (watch_ovf_out && quiet_q > 12'd8 |=> (!watch_ovf_out) [*3])
    else $error("overflow pulses too close");
  a_intv_one_cycle: assert property (intv_out |=> !intv_out)
    else $error("interval pulse too long");
endmodule

bind watch_buzzer_clock watch_buzzer_clock_props u_props (.clk_sys_in, .resetn_in, .sub_clk_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .wdog_tick_out, .watch_tick_out, .watch_ovf_out, .intv_out, .buzzer_out);

`default_nettype wire

/* testbench.sv */
// self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import watch_buzzer_clock_pkg::*;
  typedef struct { logic [15:0] a; logic [7:0] d; int w; int per; } row_t;
  localparam logic [15:0] SEL = CLK_SEL_OFFSET;
  localparam logic [15:0] WMD = WATCH_MODE_OFFSET;

  logic clk_sys_in, resetn_in, sub_clk_in, wr_in, rd_in;
  logic [15:0] addr_in;
  logic [7:0]  wdata_in, rdata_out;
  logic wdog_tick_out, watch_tick_out, watch_ovf_out, intv_out, buzzer_out;
  logic [4:0]  mon;      // monitored outputs by index
  logic [1:0]  sub_cnt;  // subsystem clock divider
  int err_count, checks_done, n;
  // write, then period of monitored output (-1: never rises)
  row_t rows [19] = '{'{SEL, 8'h00, 0, 8}, '{SEL, 8'h01, 0, 16}, '{SEL, 8'h02, 0, 32}, '{SEL, 8'h03, 0, 64},
    '{SEL, 8'h04, 0, 128}, '{SEL, 8'h05, 0, 256}, '{SEL, 8'h06, 0, 512}, '{SEL, 8'h07, 0, 2048},
    '{SEL, 8'h08, 0, 8}, '{SEL, 8'h80, 3, 512}, '{SEL, 8'ha0, 3, 1024}, '{SEL, 8'hc0, 3, 2048},
    '{SEL, 8'he0, 3, -1}, '{WMD, 8'h07, 4, 128}, '{WMD, 8'h07, 1, 4096}, '{WMD, 8'h07, 2, 2048},
    '{SEL, 8'h90, 4, 8}, '{WMD, 8'h57, 2, 4096}, '{WMD, 8'h57, 1, 256}};

  assign mon = {watch_tick_out, buzzer_out, intv_out, watch_ovf_out, wdog_tick_out};

  watch_buzzer_clock dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sub_clk_in(sub_clk_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .wdog_tick_out(wdog_tick_out), .watch_tick_out(watch_tick_out), .watch_ovf_out(watch_ovf_out),
    .intv_out(intv_out), .buzzer_out(buzzer_out));

  ////////////////////////////////////////////////////////////////
  // clocks: 25 ns system, subsystem every 8 cycles
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    sub_cnt <= sub_cnt + 2'd1;
    if (sub_cnt == 2'd3) sub_clk_in <= !sub_clk_in;
  end

  ////////////////////////////////////////////////////////////////
  // compare, bus and measuring tasks
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_int(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in   <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk8("rdata", e, rdata_out);
  endtask
  // rise-to-rise period in cycles, bounded wait
  task automatic measure(input int w, output int p);
    int k1, k2;
    p = -1;
    @(negedge clk_sys_in);
    // start at a true rise, not in the middle of a high run
    for (k1 = 0; k1 < 6000 && mon[w] === 1'b1; k1++) @(negedge clk_sys_in);
    for (k1 = 0; k1 < 6000 && mon[w] !== 1'b1; k1++) @(negedge clk_sys_in);
    for (k1 = 0; k1 < 6000 && mon[w] === 1'b1; k1++) @(negedge clk_sys_in);
    for (k2 = 0; k2 < 6000 && mon[w] !== 1'b1; k2++) @(negedge clk_sys_in);
    if (mon[w] === 1'b1) p = k1 + k2;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog against a hung run
  initial begin
    repeat (95000) @(posedge clk_sys_in);
    err_count++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////
  // main sequence: table rows, then hand-written cases
  initial begin
    resetn_in = 1'b0;
    sub_clk_in = 1'b0;
    sub_cnt = 2'd0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 16'h0000;
    wdata_in = 8'h00;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(SEL, CLK_SEL_RESET);
    wr(OSC_MODE_OFFSET, 8'h01);
    foreach (rows[i]) begin
      if (rows[i].a == SEL) wr(WMD, 8'h00);
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == SEL) rd(SEL, rows[i].d & CLK_SEL_WMASK);
      measure(rows[i].w, n);
      chk_int("period", rows[i].per, n);
    end
    // both sticky flags were set while the two functions ran together
    rd(WATCH_STATUS_OFFSET, 8'h03);
    // half-rate main clock doubles every divided period
    wr(OSC_MODE_OFFSET, 8'h00);
    wr(WMD, 8'h00);
    wr(SEL, 8'h03);
    measure(0, n);
    chk_int("half rate period", 128, n);
    // unmapped place: write ignored, reads zero
    wr(16'hff43, 8'hff);
    rd(16'hff43, 8'h00);
    rd(SEL, 8'h03);
    // second reset in mid-run
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    @(negedge clk_sys_in);
    chk8("outputs in reset", 8'h00, {3'b000, mon});
    chk8("read data in reset", 8'h00, rdata_out);
    @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(SEL, CLK_SEL_RESET);
    final_report;
  end
endmodule

`default_nettype wire
